/* tcw_partner.sv */
`timescale 1ns/1ns
module tcw_partner
(
    input wire logic clk_sys_i,
    input wire logic edge_req_i,
    input wire logic irq_capture_i,
    input wire logic irq_timebase_i,
    output logic capture_input_pin_o,
    output logic [1:0] vector_o
);
    initial capture_input_pin_o = 1'b0;
    // pin moves off the clock edge
    always @(posedge clk_sys_i)
    begin
        if (edge_req_i)
        begin
            capture_input_pin_o <= #1 ~capture_input_pin_o;
        end
    end
    assign vector_o = irq_capture_i ? 2'h1 : (irq_timebase_i ? 2'h2 : 2'h0);
endmodule

/* tcw_pkg.sv */
package tcw_pkg;
    // the timer always runs from the oscillator divided by this
    localparam int unsigned OSC_DIV = 32;
    localparam int unsigned PRE_W = $clog2(OSC_DIV);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_DIV - 1);
    // timebase periods in oscillator periods
    localparam int unsigned TB_SHORT_OSC = 8000;
    localparam int unsigned TB_LONG_OSC = 16000;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_WRAP = CNT_W'(TB_SHORT_OSC / OSC_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    // register indices and their byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_IDX = 8'h0b;
    localparam logic [ADDR_W-1:0] CAPT_IDX = 8'h0c;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_IDX * 4);
    localparam logic [ADDR_W-1:0] CAPT_ADDR = ADDR_W'(CAPT_IDX * 4);
    // control/status field positions
    localparam int unsigned B_CAP_IE = 7;
    localparam int unsigned B_CAP_FLAG = 6;
    localparam int unsigned B_TB_SEL = 5;
    localparam int unsigned B_TB_IE = 4;
    localparam int unsigned B_TB_FLAG = 3;
    localparam int unsigned B_WDOG_RF = 2;
    localparam int unsigned B_WDOG_EN = 1;
    localparam int unsigned B_WDOG_DLY = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CAPT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } tcw_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } tcw_axil_rsp_t;
endpackage

/* tcw_sync.sv */
`timescale 1ns/1ns
module tcw_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end
        else
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once the two later stages agree
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            level_o <= RST_VAL;
        else if (s2 == s3)
            level_o <= s3;
    end
endmodule

/* tcw_timer.sv */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - free-running 8-bit counter is common timebase
// - period select picks 8000 or 16000 oscillator periods
// - timebase flag set at end of selected period (every second overflow when long), read clears
// - timebase interrupt only while its enable set
// - capture interrupt only while its enable set
// - capture flag set on capture, capture read clears
// - either pin edge copies counter while flag clear
// - capture register read-only, zero after reset
// - writing one to reset flag forces watchdog reset
// - reset flag set by watchdog, cleared by detector/software
// - watchdog runs only while enabled
// - delay bit set by software, cleared each period
// - period end without refresh resets the device
// - watchdog enabled by hardware option or software
// - optional watchdog reset on halt instruction
// - enabled capture interrupt can wake from halt
// - timer clocked from oscillator divided by 32
// - capture interrupt has its own request line
// - timebase interrupt on separate lower-priority line
module tcw_timer
#(
    parameter int unsigned WDOG_PERIOD_OVF = 8
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire tcw_pkg::tcw_axil_req_t s_axil_req_i,
    output tcw_pkg::tcw_axil_rsp_t s_axil_rsp_o,
    input wire logic capture_input_pin_i,
    input wire logic cfg_wdog_hw_enable_i,
    input wire logic cfg_wdog_halt_reset_i,
    input wire logic halt_exec_i,
    input wire logic low_voltage_detector_reset_i,
    output logic irq_capture_o,
    output logic irq_timebase_o,
    output logic halt_wake_o,
    output logic wdog_reset_o
);
    import tcw_pkg::*;

    localparam int unsigned WCNT_W = $clog2(WDOG_PERIOD_OVF + 1);
    localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WDOG_PERIOD_OVF - 1);

    logic [PRE_W-1:0] pre;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic ovf;
    logic tb_half;
    logic tb_event;
    logic cap_ie;
    logic cap_flag;
    logic tb_sel;
    logic tb_ie;
    logic tb_flag;
    logic wdog_rf;
    logic rf_read_seen;
    logic wdog_en_sw;
    logic wdog_delay;
    logic wdog_on;
    logic [WCNT_W-1:0] wcnt;
    logic wdog_end;
    logic dly_set;
    logic wdog_rst_evt;
    logic opt_done;
    logic opt_wdog_hw;
    logic opt_halt_rst;
    logic [CNT_W-1:0] capt;
    logic pin_level;
    logic pin_prev;
    logic [4:0] pin_armed;
    logic cap_evt;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic wr_fire;
    logic wr_ctrl;
    logic rd_fire;
    logic rd_ctrl;
    logic rd_capt;
    logic [7:0] ctrl_view;

    // options are caught once, on the first edge after reset release
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            opt_done <= 1'b0;
            opt_wdog_hw <= 1'b0;
            opt_halt_rst <= 1'b0;
        end
        else if (!opt_done)
        begin
            opt_done <= 1'b1;
            opt_wdog_hw <= cfg_wdog_hw_enable_i;
            opt_halt_rst <= cfg_wdog_halt_reset_i;
        end
    end

    assign tick = (pre == PRE_LAST);

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pre <= '0;
        else
            pre <= pre + 1'b1;
    end

    assign ovf = tick && (cnt == CNT_WRAP);

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt <= CNT_RST;
        else if (ovf)
            cnt <= CNT_RST;
        else if (tick)
            cnt <= cnt + 1'b1;
    end

    // long period takes every second overflow
    assign tb_event = ovf && (!tb_sel || tb_half);

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tb_half <= 1'b0;
        else if (ovf)
            tb_half <= !tb_half;
    end

    tcw_sync #(.RST_VAL(1'b0)) u_pin_sync
    (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(capture_input_pin_i),
        .level_o(pin_level)
    );

    // edges count only once the synchroniser holds the real pin level,
    // so a pin resting high at reset release does not fake a capture
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_prev <= 1'b0;
            pin_armed <= '0;
        end
        else
        begin
            pin_prev <= pin_level;
            pin_armed <= {pin_armed[3:0], 1'b1};
        end
    end

    // both edges, only while flag clear
    assign cap_evt = pin_armed[4] && (pin_level != pin_prev) && !cap_flag;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            capt <= CAPT_RST;
        else if (cap_evt)
            capt <= cnt;
    end

    // set wins over the clearing read
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cap_flag <= CTRL_RST[B_CAP_FLAG];
        else if (cap_evt)
            cap_flag <= 1'b1;
        else if (rd_capt)
            cap_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tb_flag <= CTRL_RST[B_TB_FLAG];
        else if (tb_event)
            tb_flag <= 1'b1;
        else if (rd_ctrl)
            tb_flag <= 1'b0;
    end

    // plain software bits
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cap_ie <= CTRL_RST[B_CAP_IE];
            tb_sel <= CTRL_RST[B_TB_SEL];
            tb_ie <= CTRL_RST[B_TB_IE];
            wdog_en_sw <= CTRL_RST[B_WDOG_EN];
        end
        else if (wr_ctrl)
        begin
            cap_ie <= w_data[B_CAP_IE];
            tb_sel <= w_data[B_TB_SEL];
            tb_ie <= w_data[B_TB_IE];
            wdog_en_sw <= w_data[B_WDOG_EN];
        end
    end

    // hardware option forces the watchdog on
    assign wdog_on = opt_wdog_hw || wdog_en_sw;
    assign wdog_end = ovf && (wcnt == WCNT_LAST);
    assign dly_set = wr_ctrl && w_data[B_WDOG_DLY];

    // period count runs only while enabled
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wcnt <= '0;
        else if (!wdog_on || wdog_end)
            wcnt <= '0;
        else if (ovf)
            wcnt <= wcnt + 1'b1;
    end

    // a refresh landing on the period end counts for the next one
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wdog_delay <= CTRL_RST[B_WDOG_DLY];
        else if (dly_set)
            wdog_delay <= 1'b1;
        else if (wdog_end)
            wdog_delay <= 1'b0;
    end

    assign wdog_rst_evt = (wr_ctrl && w_data[B_WDOG_RF])
        || (wdog_on && wdog_end && !wdog_delay)
        || (opt_halt_rst && halt_exec_i);

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wdog_reset_o <= 1'b0;
        else
            wdog_reset_o <= wdog_rst_evt;
    end

    // clear by software only after a status read
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wdog_rf <= CTRL_RST[B_WDOG_RF];
            rf_read_seen <= 1'b0;
        end
        else if (wdog_rst_evt)
        begin
            wdog_rf <= 1'b1;
            rf_read_seen <= 1'b0;
        end
        else if (low_voltage_detector_reset_i)
        begin
            wdog_rf <= 1'b0;
            rf_read_seen <= 1'b0;
        end
        else if (wr_ctrl && rf_read_seen)
        begin
            wdog_rf <= 1'b0;
            rf_read_seen <= 1'b0;
        end
        else if (rd_ctrl)
            rf_read_seen <= 1'b1;
    end

    assign irq_capture_o = cap_ie && cap_flag;
    assign irq_timebase_o = tb_ie && tb_flag;
    // capture or timebase request wakes the core from halt
    assign halt_wake_o = irq_capture_o || irq_timebase_o;

    always_comb
    begin
        ctrl_view = CTRL_RST;
        ctrl_view[B_CAP_IE] = cap_ie;
        ctrl_view[B_CAP_FLAG] = cap_flag;
        ctrl_view[B_TB_SEL] = tb_sel;
        ctrl_view[B_TB_IE] = tb_ie;
        ctrl_view[B_TB_FLAG] = tb_flag;
        ctrl_view[B_WDOG_RF] = wdog_rf;
        ctrl_view[B_WDOG_EN] = wdog_on;
        ctrl_view[B_WDOG_DLY] = wdog_delay;
    end

    // bus write side: address and data may arrive in either order
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_ctrl = wr_fire && (aw_addr == CTRL_ADDR) && w_strb[0];

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (wr_fire)
            aw_held <= 1'b0;
        else if (s_axil_req_i.awvalid && !aw_held && !bvalid)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axil_req_i.awaddr;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (wr_fire)
            w_held <= 1'b0;
        else if (s_axil_req_i.wvalid && !w_held && !bvalid)
        begin
            w_held <= 1'b1;
            w_data <= s_axil_req_i.wdata;
            w_strb <= s_axil_req_i.wstrb;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= (aw_addr == CTRL_ADDR || aw_addr == CAPT_ADDR) ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axil_req_i.bready)
            bvalid <= 1'b0;
    end

    // bus read side: reads carry the flag-clearing side effects
    assign rd_fire = s_axil_req_i.arvalid && !rvalid;
    assign rd_ctrl = rd_fire && (s_axil_req_i.araddr == CTRL_ADDR);
    assign rd_capt = rd_fire && (s_axil_req_i.araddr == CAPT_ADDR);

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
        end
        else if (rd_fire)
        begin
            rvalid <= 1'b1;
            rresp <= (rd_ctrl || rd_capt) ? RESP_OKAY : RESP_DECERR;
            rdata <= rd_ctrl ? {24'h000000, ctrl_view}
                : (rd_capt ? {24'h000000, capt} : 32'h00000000);
        end
        else if (s_axil_req_i.rready)
            rvalid <= 1'b0;
    end

    always_comb
    begin
        s_axil_rsp_o.awready = !aw_held && !bvalid;
        s_axil_rsp_o.wready = !w_held && !bvalid;
        s_axil_rsp_o.bresp = bresp;
        s_axil_rsp_o.bvalid = bvalid;
        s_axil_rsp_o.arready = !rvalid;
        s_axil_rsp_o.rdata = rdata;
        s_axil_rsp_o.rresp = rresp;
        s_axil_rsp_o.rvalid = rvalid;
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_count_step: assert property (
        tick |=> cnt == (($past(cnt) == CNT_WRAP) ? CNT_RST : $past(cnt) + 8'h01))
        else $error("counter did not step on tick");
    a_tick_spacing: assert property (
        tick |=> !tick [*8])
        else $error("prescaler ticks too close");
    a_long_period: assert property (
        ovf && tb_sel && !tb_half |=> !tb_flag || $past(tb_flag))
        else $error("long period flagged on odd overflow");
    a_tb_flag_set: assert property (
        tb_event |=> tb_flag)
        else $error("timebase flag not set");
    a_tb_flag_clr: assert property (
        rd_ctrl && !tb_event |=> !tb_flag)
        else $error("timebase flag not cleared by read");
    a_tb_irq_gate: assert property (
        !tb_ie |-> !irq_timebase_o)
        else $error("timebase request while disabled");
    a_cap_irq_gate: assert property (
        irq_capture_o |-> cap_ie && cap_flag)
        else $error("capture request while disabled");
    a_cap_irq_raise: assert property (
        cap_evt && cap_ie && !wr_ctrl |=> irq_capture_o)
        else $error("capture request missing while enabled");
    a_tb_irq_raise: assert property (
        tb_event && tb_ie && !wr_ctrl |=> irq_timebase_o)
        else $error("timebase request missing while enabled");
    a_cap_value: assert property (
        cap_evt |=> capt == $past(cnt) && cap_flag)
        else $error("capture did not take counter");
    a_cap_hold: assert property (
        cap_flag && !rd_capt |=> $stable(capt) && cap_flag)
        else $error("capture changed while flag set");
    a_force_reset: assert property (
        wr_ctrl && w_data[B_WDOG_RF] |=> wdog_reset_o && wdog_rf)
        else $error("forced watchdog reset missing");
    a_timeout_reset: assert property (
        wdog_on && wdog_end && !wdog_delay |=> wdog_reset_o ##1 !wdog_reset_o [*2])
        else $error("watchdog timeout reset missing or long");
    a_delay_clear: assert property (
        wdog_end && !dly_set |=> !wdog_delay)
        else $error("delay bit survived period end");
    a_wdog_idle: assert property (
        !wdog_on |=> wcnt == '0)
        else $error("watchdog counts while disabled");
    a_halt_reset: assert property (
        opt_halt_rst && halt_exec_i |=> wdog_reset_o)
        else $error("halt did not reset");
endmodule

/* timebase_capture_watchdog_timer_tb_top.sv */
`timescale 1ns/1ns
module timebase_capture_watchdog_timer_tb_top;
    import tcw_pkg::*;
    logic clk_sys_i, resetn_i, pin, edge_req, hw_en, halt_rst, halt, low_voltage_detector;
    logic irq_cp, irq_tb, wake, wd_rst, tb_q, cp_q;
    logic [1:0] vec, r;
    logic [31:0] q;
    logic [7:0] v1;
    tcw_axil_req_t req;
    tcw_axil_rsp_t rsp;
    int mismatches, n_compared, cyc, n_tb, n_wd, n_cp, t_tb, t_cp, t1, k;

    tcw_timer #(.WDOG_PERIOD_OVF(1)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .s_axil_req_i(req), .s_axil_rsp_o(rsp), .capture_input_pin_i(pin),
        .cfg_wdog_hw_enable_i(hw_en), .cfg_wdog_halt_reset_i(halt_rst), .halt_exec_i(halt),
        .low_voltage_detector_reset_i(low_voltage_detector), .irq_capture_o(irq_cp), .irq_timebase_o(irq_tb),
        .halt_wake_o(wake), .wdog_reset_o(wd_rst));

    tcw_partner partner (.clk_sys_i(clk_sys_i), .edge_req_i(edge_req), .irq_capture_i(irq_cp),
        .irq_timebase_i(irq_tb), .capture_input_pin_o(pin), .vector_o(vec));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // event counters and the run ceiling
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        tb_q <= irq_tb;
        cp_q <= irq_cp;
        if (irq_tb === 1'b1 && tb_q === 1'b0)
        begin
            n_tb <= n_tb + 1;
            t_tb <= cyc;
        end
        if (irq_cp === 1'b1 && cp_q === 1'b0)
        begin
            n_cp <= n_cp + 1;
            t_cp <= cyc;
        end
        if (wd_rst === 1'b1)
        begin
            n_wd <= n_wd + 1;
        end
        if (cyc == 90000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic pa, pw, ra, rw, v;
        pa = 1'b1;
        pw = wr;
        v = 1'b0;
        @(posedge clk_sys_i);
        if (wr)
        begin
            req.awaddr <= a;
            req.awvalid <= 1'b1;
            req.wdata <= {24'h0, d};
            req.wstrb <= 4'h1;
            req.wvalid <= 1'b1;
            req.bready <= 1'b1;
        end
        else
        begin
            req.araddr <= a;
            req.arvalid <= 1'b1;
            req.rready <= 1'b1;
        end
        while (v !== 1'b1)
        begin
            @(negedge clk_sys_i);
            ra = wr ? rsp.awready : rsp.arready;
            rw = rsp.wready;
            v = wr ? rsp.bvalid : rsp.rvalid;
            q = rsp.rdata;
            r = wr ? rsp.bresp : rsp.rresp;
            @(posedge clk_sys_i);
            if (pa && ra)
            begin
                pa = 1'b0;
                req.awvalid <= 1'b0;
                req.arvalid <= 1'b0;
            end
            if (pw && rw)
            begin
                pw = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask

    task automatic wrc(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
        chk("write resp", 32'(RESP_OKAY), 32'(r));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        xfer(1'b0, a, 8'h00);
        chk("read resp", 32'(RESP_OKAY), 32'(r));
        chk("read data", {24'h0, e & m}, q & {24'hffffff, m});
    endtask

    function automatic int cnt(input int sel);
        return sel == 0 ? n_tb : (sel == 1 ? n_wd : n_cp);
    endfunction

    task automatic await(input int sel, input int lim);
        int k0;
        int i;
        k0 = cnt(sel);
        i = 0;
        while (cnt(sel) == k0 && i < lim)
        begin
            @(posedge clk_sys_i);
            i++;
        end
        chk("event wait", 32'h1, 32'(i < lim));
    endtask

    task automatic pulse(input int sel);
        @(posedge clk_sys_i);
        case (sel)
            0: edge_req <= 1'b1;
            1: halt <= 1'b1;
            default: low_voltage_detector <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        edge_req <= 1'b0;
        halt <= 1'b0;
        low_voltage_detector <= 1'b0;
    endtask

    // counter advances one step per 32 clocks, wrapping after 250 steps
    function automatic int cap_exp(input int g, input int dt);
        int e;
        e = (dt / 32) % 250;
        if (g == (e + 1) % 250 || g == (e + 249) % 250)
        begin
            e = g;
        end
        return e;
    endfunction

    task automatic do_reset(input logic hw);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        hw_en <= hw;
        halt_rst <= hw;
        repeat (16) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rdc(CAPT_ADDR, CAPT_RST, 8'hff);
    endtask

    initial
    begin
        resetn_i = 1'b0;
        req = '0;
        {edge_req, hw_en, halt_rst, halt, low_voltage_detector} = 5'h00;
        void'($urandom(32'h06adc244));
        do_reset(1'b0);
        rdc(CTRL_ADDR, CTRL_RST, 8'hff);
        xfer(1'b0, 8'h00, 8'h00);
        chk("unmapped read resp", 32'(RESP_DECERR), 32'(r));
        chk("unmapped read data", 32'h0, q);
        xfer(1'b1, 8'h10, 8'($urandom));
        chk("unmapped write resp", 32'(RESP_DECERR), 32'(r));
        wrc(CAPT_ADDR, 8'($urandom));
        rdc(CAPT_ADDR, CAPT_RST, 8'hff);
        wrc(CTRL_ADDR, 8'h80);
        pulse(0);
        await(2, 40);
        chk("capture irq", 32'h1, 32'(irq_cp));
        chk("halt wake", 32'h1, 32'(wake));
        t1 = t_cp;
        pulse(0);
        repeat (300) @(posedge clk_sys_i);
        rdc(CAPT_ADDR, 8'h00, 8'h00);
        v1 = q[7:0];
        chk("capture irq cleared", 32'h0, 32'(irq_cp));
        repeat (3)
        begin
            repeat (200 + $urandom % 1000) @(posedge clk_sys_i);
            pulse(0);
            await(2, 40);
            rdc(CAPT_ADDR, 8'h00, 8'h00);
            k = (int'(q[7:0]) + 250 - int'(v1)) % 250;
            chk("capture delta", 32'(cap_exp(k, t_cp - t1)), 32'(k));
            v1 = q[7:0];
            t1 = t_cp;
        end
        wrc(CTRL_ADDR, 8'h00);
        pulse(0);
        repeat (20) @(posedge clk_sys_i);
        chk("masked capture irq", 32'h0, 32'(irq_cp));
        rdc(CTRL_ADDR, 8'h40, 8'h40);
        rdc(CAPT_ADDR, 8'h00, 8'h00);
        rdc(CTRL_ADDR, 8'h00, 8'h40);
        wrc(CTRL_ADDR, 8'h90);
        await(0, 8100);
        rdc(CTRL_ADDR, 8'h98, 8'hff);
        t1 = t_tb;
        await(0, 8100);
        chk("short period", 32'd8000, 32'(t_tb - t1));
        wrc(CTRL_ADDR, 8'hb8);
        rdc(CTRL_ADDR, 8'hb8, 8'hff);
        rdc(CTRL_ADDR, 8'hb0, 8'hff);
        await(0, 16100);
        rdc(CTRL_ADDR, 8'hb8, 8'hff);
        t1 = t_tb;
        chk("timebase irq cleared", 32'h0, 32'(irq_tb));
        await(0, 16100);
        chk("long period", 32'd16000, 32'(t_tb - t1));
        pulse(0);
        await(2, 40);
        chk("vector order", 32'h1, 32'(vec));
        chk("both irq lines", 32'h3, {30'h0, irq_tb, irq_cp});
        rdc(CAPT_ADDR, 8'h00, 8'h00);
        chk("watchdog off", 32'h0, 32'(n_wd));
        k = n_tb;
        repeat (4)
        begin
            wrc(CTRL_ADDR, 8'h83);
            repeat (2500 + $urandom % 500) @(posedge clk_sys_i);
        end
        chk("refreshed watchdog", 32'h0, 32'(n_wd));
        chk("masked timebase irq", 32'(k), 32'(n_tb));
        rdc(CTRL_ADDR, 8'h8a, 8'hfe);
        wrc(CTRL_ADDR, 8'h82);
        await(1, 16100);
        rdc(CTRL_ADDR, 8'h06, 8'h07);
        wrc(CTRL_ADDR, 8'h80);
        rdc(CTRL_ADDR, 8'h00, 8'h07);
        k = n_wd;
        wrc(CTRL_ADDR, 8'h84);
        repeat (4) @(posedge clk_sys_i);
        chk("forced reset", 32'(k + 1), 32'(n_wd));
        rdc(CTRL_ADDR, 8'h04, 8'h07);
        pulse(2);
        rdc(CTRL_ADDR, 8'h00, 8'h04);
        do_reset(1'b1);
        repeat (8) @(posedge clk_sys_i);
        rdc(CTRL_ADDR, 8'h02, 8'h46);
        k = n_wd;
        pulse(1);
        repeat (4) @(posedge clk_sys_i);
        chk("halt reset", 32'(k + 1), 32'(n_wd));
        rdc(CTRL_ADDR, 8'h04, 8'h04);
        conclude();
    end
endmodule
